// ==== common/lcdd_params.svh ====
// Build options, register map and timing constants of the segment LCD driver
`ifndef LCDD_PARAMS_SVH
`define LCDD_PARAMS_SVH

// Register indices; byte address is four times the index
`define LCDD_MEM_IDX     12'h090
`define LCDD_MEM_WORDS   12'h020
`define LCDD_SW_IDX      12'h0fb
`define LCDD_STAT_IDX    12'h100
`define LCDD_SW_BIT      3
`define LCDD_SW_RESET    1'b0
`define LCDD_RD_ZERO     32'h0000_0000

// Build options: duty code, half bias, DC pair mask (bit n = pins 2n, 2n+1)
`define LCDD_DUTY_BUILD  2'h0
`define LCDD_HALF_BIAS   1'b0
`define LCDD_DC_PAIRS    10'h000

// Source oscillator derived from the system clock
`define LCDD_CLK_HZ      25'd20000000
`define LCDD_OSC_HZ      25'd32768

// Oscillator periods per frame for each drive format
`define LCDD_FRAME_QUART 11'd1024
`define LCDD_FRAME_THIRD 11'd768
`define LCDD_FRAME_HALF  11'd1024
`define LCDD_FRAME_STAT  11'd1024

// Drive level codes on the pins
`define LCDD_LV_VDD      3'h0
`define LCDD_LV_L1       3'h1
`define LCDD_LV_L2       3'h2
`define LCDD_LV_L3       3'h3
`define LCDD_LV_VSS      3'h4

`endif

// ==== common/lcdd_pkg.sv ====
// Types shared by the segment LCD driver
package lcdd_pkg;
	typedef logic [2:0] lcdd_level_t;
	typedef enum logic [1:0] {
		LCDD_QUARTER = 2'h0,
		LCDD_THIRD   = 2'h1,
		LCDD_HALF    = 2'h2
	} lcdd_duty_t;
	typedef logic [4*3-1:0]  lcdd_com_bus_t;
	typedef logic [20*3-1:0] lcdd_seg_bus_t;
endpackage

// ==== rtl/lcdd_segment_driver.sv ====
// Segment LCD driver: display memory, drive switch, frame scan and pin levels
//
// Behaviour
// - Four common and twenty segment outputs drive up to eighty segments.
// - Duty is quarter by default, third or half as build option; 1/3 bias.
// - Half bias build option merges first and second levels into one.
// - Frames run 32 Hz in quarter/half duty and 42.7 Hz in third duty.
// - Quarter duty scans commons 0-3, third 0-2, half 0-1.
// - Drive switch bit 3 selects static drive; reads back, resets to 0.
// - Static frame lasts 1024 oscillator periods, 32 Hz.
// - Static drive treats data of all four common positions as valid.
// - Display memory is 32 write-only 4-bit words; reads return nothing.
// - Bit one lights its segment; memory is not cleared by reset.
// - Memory bit to segment and common mapping is fixed at build.
// - Pin pairs may be DC outputs showing their common 0 bit.
//
// The AHB-Lite slave port was chosen for this implementation.
`include "lcdd_params.svh"
`timescale 1ns/1ps
module lcdd_segment_driver (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  resetn,
	// AHB-Lite slave
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	// Panel pins as level codes, three bits per pin
	output lcdd_pkg::lcdd_com_bus_t    common_outputs,
	output lcdd_pkg::lcdd_seg_bus_t    segment_outputs
);
	import lcdd_pkg::*;

	// Build mapping: word and bit of memory that feed segment s at common c
	function automatic int mapWord(input int s, input int c);
		mapWord = s;
	endfunction
	function automatic int mapBit(input int s, input int c);
		mapBit = c;
	endfunction

	lcdd_duty_t  duty;
	logic        halfBias;
	assign duty     = lcdd_duty_t'(`LCDD_DUTY_BUILD);
	assign halfBias = `LCDD_HALF_BIAS;

	// ---------------- Bus slave ----------------
	logic [3:0]  dmem [32];
	logic        staticSel_reg;
	logic        staticAct_reg;
	logic        wrPend_reg;
	logic [11:0] wrIdx_reg;
	logic [31:0] hrdata_reg;
	logic        hreadyout_reg;
	logic [1:0]  slot_reg;

	wire         accept   = hsel & htrans[1] & hready;
	wire         addrHigh = |haddr[31:14];
	wire  [11:0] aIdx     = haddr[13:2];
	wire  [11:0] memOff   = aIdx - `LCDD_MEM_IDX;
	wire         aMem     = !addrHigh && aIdx >= `LCDD_MEM_IDX
	                        && memOff < `LCDD_MEM_WORDS;
	wire         aSw      = !addrHigh && aIdx == `LCDD_SW_IDX;
	wire         aStat    = !addrHigh && aIdx == `LCDD_STAT_IDX;
	wire  [11:0] wrOff    = wrIdx_reg - `LCDD_MEM_IDX;
	wire         wrMem    = wrPend_reg && wrIdx_reg >= `LCDD_MEM_IDX
	                        && wrOff < `LCDD_MEM_WORDS;
	wire         wrSw     = wrPend_reg && wrIdx_reg == `LCDD_SW_IDX;

	// Read mux: memory and unmapped words read as zero
	logic [31:0] rdNext;
	always_comb begin
		rdNext = `LCDD_RD_ZERO;
		// switch read back
		// A write still in its data phase is forwarded so back-to-back reads see it
		if (aSw)
			rdNext[`LCDD_SW_BIT] = wrSw ? hwdata[`LCDD_SW_BIT] : staticSel_reg;
		if (aStat)
			rdNext[2:0] = {slot_reg, staticAct_reg};
		if (aMem)
			rdNext = `LCDD_RD_ZERO;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wrPend_reg    <= 1'b0;
			wrIdx_reg     <= 12'h000;
			hrdata_reg    <= `LCDD_RD_ZERO;
			hreadyout_reg <= 1'b0;
		end else begin
			hreadyout_reg <= 1'b1;
			wrPend_reg    <= accept & hwrite;
			if (accept)
				wrIdx_reg <= aIdx;
			if (accept && !hwrite)
				hrdata_reg <= rdNext;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			staticSel_reg <= `LCDD_SW_RESET;
		else if (wrSw)
			staticSel_reg <= hwdata[`LCDD_SW_BIT];
	end

	// write-only memory, left unreset on purpose
	always_ff @(posedge clk_sys) begin
		if (wrMem)
			dmem[wrOff[4:0]] <= hwdata[3:0];
	end

	assign hreadyout = hreadyout_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// ---------------- Oscillator and frame timing ----------------
	// Fractional divider keeps the long-run oscillator rate exact
	logic [24:0] phase_reg;
	logic        oscTick_reg;
	wire  [24:0] phaseSum = phase_reg + `LCDD_OSC_HZ;
	wire         phaseWrap = phaseSum >= `LCDD_CLK_HZ;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			phase_reg   <= 25'h0000000;
			oscTick_reg <= 1'b0;
		end else begin
			oscTick_reg <= phaseWrap;
			phase_reg   <= phaseWrap ? phaseSum - `LCDD_CLK_HZ : phaseSum;
		end
	end

	// Slot count and frame length for the format in force
	logic [10:0] frameLen;
	logic [1:0]  lastSlot;
	always_comb begin
		frameLen = `LCDD_FRAME_QUART;
		lastSlot = 2'h3;
		if (staticAct_reg) begin
			frameLen = `LCDD_FRAME_STAT;
			lastSlot = 2'h0;
		end else begin
			unique case (duty)
				LCDD_QUARTER: begin
					frameLen = `LCDD_FRAME_QUART;
					lastSlot = 2'h3;
				end
				LCDD_THIRD: begin
					frameLen = `LCDD_FRAME_THIRD;
					lastSlot = 2'h2;
				end
				LCDD_HALF: begin
					frameLen = `LCDD_FRAME_HALF;
					lastSlot = 2'h1;
				end
				default: begin
					frameLen = `LCDD_FRAME_QUART;
					lastSlot = 2'h3;
				end
			endcase
		end
	end

	// Each slot splits in two halves of opposite polarity, keeping the cell DC free
	wire  [2:0]  slotCount = {1'b0, lastSlot} + 3'h1;
	wire  [10:0] halfLen   = frameLen / {7'h00, slotCount, 1'b0};
	logic [10:0] halfCnt_reg;
	logic        pol_reg;
	wire         halfEnd   = oscTick_reg && halfCnt_reg == halfLen - 11'h001;
	wire         frameEnd  = halfEnd && pol_reg && slot_reg == lastSlot;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			halfCnt_reg <= 11'h000;
			pol_reg     <= 1'b0;
			slot_reg    <= 2'h0;
		end else if (halfEnd) begin
			halfCnt_reg <= 11'h000;
			pol_reg     <= ~pol_reg;
			if (pol_reg)
				slot_reg <= (slot_reg == lastSlot) ? 2'h0 : slot_reg + 2'h1;
		end else if (oscTick_reg) begin
			halfCnt_reg <= halfCnt_reg + 11'h001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn)
			staticAct_reg <= `LCDD_SW_RESET;
		else if (frameEnd)
			staticAct_reg <= staticSel_reg;
	end

	// ---------------- Level selection ----------------
	// half bias merges intermediate levels
	wire  [2:0] lvMidHi = `LCDD_LV_L1;
	wire  [2:0] lvMidLo = halfBias ? `LCDD_LV_L1 : `LCDD_LV_L2;

	logic [4*3-1:0]  comNext;
	logic [20*3-1:0] segNext;
	logic [4*3-1:0]  com_reg;
	logic [20*3-1:0] seg_reg;

	genvar gc, gs;
	generate
		for (gc = 0; gc < 4; gc++) begin : g_com
			localparam logic [1:0] GIDX = 2'(gc);
			wire inUse = GIDX <= lastSlot;
			wire sel   = staticAct_reg || (inUse && slot_reg == GIDX);
			assign comNext[gc*3 +: 3] = sel ? (pol_reg ? `LCDD_LV_VDD : `LCDD_LV_L3)
			                                : (pol_reg ? lvMidLo : lvMidHi);
		end
		for (gs = 0; gs < 20; gs++) begin : g_seg
			localparam int W0 = mapWord(gs, 0);
			localparam int W1 = mapWord(gs, 1);
			localparam int W2 = mapWord(gs, 2);
			localparam int W3 = mapWord(gs, 3);
			localparam int B0 = mapBit(gs, 0);
			localparam int B1 = mapBit(gs, 1);
			localparam int B2 = mapBit(gs, 2);
			localparam int B3 = mapBit(gs, 3);
			wire [3:0] bits = {dmem[W3][B3], dmem[W2][B2], dmem[W1][B1], dmem[W0][B0]};
			// all four positions count in static drive
			wire on = staticAct_reg ? |bits : bits[slot_reg];
			wire [9:0] dc = `LCDD_DC_PAIRS >> (gs / 2);
			wire [2:0] scan = on ? (pol_reg ? `LCDD_LV_L3 : `LCDD_LV_VDD)
			                     : (pol_reg ? lvMidHi : lvMidLo);
			// DC pair shows common 0 bit
			assign segNext[gs*3 +: 3] = dc[0] ? (bits[0] ? `LCDD_LV_VDD : `LCDD_LV_VSS)
			                                  : scan;
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			com_reg <= {4{`LCDD_LV_VDD}};
			seg_reg <= {20{`LCDD_LV_VDD}};
		end else begin
			com_reg <= comNext;
			seg_reg <= segNext;
		end
	end

	assign common_outputs  = com_reg;
	assign segment_outputs = seg_reg;
endmodule

// ==== dv/lcdd_checker.sv ====
// Port checker for the segment LCD driver
`timescale 1ns/1ps
`include "lcdd_params.svh"
module lcdd_checker (
	// Clock, reset, bus
	input wire logic                   clk_sys,
	input wire logic                   resetn,
	input wire logic                   hsel,
	input wire logic [31:0]            haddr,
	input wire logic [1:0]             htrans,
	input wire logic                   hwrite,
	input wire logic                   hready,
	input wire logic                   hreadyout,
	input wire logic                   hresp,
	input wire logic [31:0]            hrdata,
	// Panel pins
	input wire lcdd_pkg::lcdd_com_bus_t common_outputs,
	input wire lcdd_pkg::lcdd_seg_bus_t segment_outputs
);
	import lcdd_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire        rdAcc = hsel && htrans[1] && hready && !hwrite && haddr[31:14] == 18'h0;
	wire [11:0] rdIdx = haddr[13:2];
	wire        rdMem = rdAcc && rdIdx >= `LCDD_MEM_IDX && rdIdx < `LCDD_MEM_IDX + `LCDD_MEM_WORDS;
	wire        rdSw  = rdAcc && rdIdx == `LCDD_SW_IDX;
	property p_okay; hresp == 1'b0; endproperty
	property p_ready; $past(resetn) |-> hreadyout; endproperty
	property p_memrd; rdMem |=> hrdata == 32'h0; endproperty
	property p_swrd; rdSw |=> hrdata[31:4] == 28'h0 && hrdata[2:0] == 3'h0; endproperty
	property p_comcode;
		!(common_outputs[2] | common_outputs[5] | common_outputs[8] | common_outputs[11]);
	endproperty
	property p_compol;
		common_outputs[3] == common_outputs[0] && common_outputs[6] == common_outputs[0]
			&& common_outputs[9] == common_outputs[0];
	endproperty
	// Unwritten memory leaves only bit 1 of the segment code unknown; bit 0, compared here, still follows the polarity
	property p_segpol; not ($past(hreadyout, 2) && segment_outputs[0] == common_outputs[0]); endproperty
	property p_hold; $changed(common_outputs) |=> $stable(common_outputs) [*8]; endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	a_ready: assert property (p_ready) else $error("wait state seen");
	a_memrd: assert property (p_memrd) else $error("memory read not zero");
	a_swrd: assert property (p_swrd) else $error("switch spare bits set");
	a_comcode: assert property (p_comcode) else $error("common level out of range");
	a_compol: assert property (p_compol) else $error("commons differ in polarity");
	a_segpol: assert property (p_segpol) else $error("segment polarity wrong");
	a_hold: assert property (p_hold) else $error("common level too short");
	c_mem: cover property (rdMem);
	c_sw: cover property (rdSw);
	c_flip: cover property ($fell(common_outputs[0]));
endmodule
bind lcdd_segment_driver lcdd_checker u_chk (.clk_sys, .resetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .common_outputs, .segment_outputs);

// ==== dv/lcdd_panel_model.sv ====
// Behavioural panel that reports which segments are lit
`timescale 1ns/1ps
module lcdd_panel_model (
	// Pin levels from the driver
	input wire lcdd_pkg::lcdd_com_bus_t comIn,
	input wire lcdd_pkg::lcdd_seg_bus_t segIn,
	// Lit map, bit 4*segment+common
	output logic [79:0]                 litMap
);
	import lcdd_pkg::*;
	always_comb begin
		lcdd_level_t cl;
		lcdd_level_t sl;
		for (int s = 0; s < 20; s++) begin
			for (int c = 0; c < 4; c++) begin
				cl = comIn[3*c+:3];
				sl = segIn[3*s+:3];
				litMap[4*s+c] = (cl == 3'h3 && sl == 3'h0) || (cl == 3'h0 && sl == 3'h3);
			end
		end
	end
endmodule

// ==== dv/lcdd_segment_driver_test.sv ====
// Bench for the segment LCD driver: registers and panel scan
`timescale 1ns/1ps
`include "lcdd_params.svh"
module lcdd_segment_driver_test;
	import lcdd_pkg::*;
	logic          clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]    htrans;
	logic [31:0]   haddr, hwdata, hrdata, q;
	lcdd_com_bus_t common_outputs;
	lcdd_seg_bus_t segment_outputs;
	logic [79:0]   litMap;
	int            error_cnt = 0, n_compared = 0, cyc = 0, rel = 0, hs;
	lcdd_segment_driver dut (.clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .common_outputs, .segment_outputs);
	lcdd_panel_model panel (.comIn(common_outputs), .segIn(segment_outputs), .litMap);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Ceiling covers one half slot plus setup
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 90000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] ix, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {18'h0, ix, 2'h0};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	initial begin
		{resetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hs = int'(64'(`LCDD_CLK_HZ) * (`LCDD_FRAME_QUART / 8) / `LCDD_OSC_HZ);
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		rel = cyc;
		repeat (2) @(posedge clk_sys);
		bus(0, `LCDD_SW_IDX, 0);
		chk(q, 0, "switch reset");
		bus(1, `LCDD_SW_IDX, 32'hf);
		bus(0, `LCDD_SW_IDX, 0);
		chk(q, 32'h8, "switch readback");
		bus(0, `LCDD_STAT_IDX, 0);
		chk(q, 0, "static before frame end");
		bus(1, `LCDD_SW_IDX, 0);
		bus(0, `LCDD_MEM_IDX, 0);
		chk(q, 0, "memory read");
		bus(0, 12'h0fa, 0);
		chk(q, 0, "unmapped read");
		$display("registers done");
		for (int s = 0; s < 32; s++) bus(1, `LCDD_MEM_IDX + 12'(s), s[0] ? 32'h1 : 32'he);
		repeat (3) @(posedge clk_sys);
		chk(common_outputs, {3'h1, 3'h1, 3'h1, 3'h3}, "commons first half");
		for (int s = 0; s < 20; s++) begin
			chk(segment_outputs[3*s+:3], s[0] ? 0 : 2, "segment first half");
			for (int c = 0; c < 4; c++) chk(litMap[4*s+c], c == 0 && s[0], "lit map");
		end
		$display("first half done");
		while (common_outputs[2:0] === 3'h3 && cyc < 85000) @(posedge clk_sys);
		chk(cyc - rel > hs - 8 && cyc - rel < hs + 8, 1, "half slot length");
		chk(common_outputs, {3'h2, 3'h2, 3'h2, 3'h0}, "commons second half");
		for (int s = 0; s < 20; s++) begin
			chk(segment_outputs[3*s+:3], s[0] ? 3 : 1, "segment second half");
		end
		$display("second half done");
		close_out();
	end
endmodule
